//--- core/scrb_pkg.sv
package scrb_pkg;
  // word layout on the serial link
  localparam int WORD_W = 24;
  localparam int SEL_W = 3;
  localparam int CNT_W = 5;
  // register select codes
  localparam logic [2:0] SEL_CHANNEL = 3'h0;
  localparam logic [2:0] SEL_REFMOD = 3'h1;
  localparam logic [2:0] SEL_PHASE = 3'h2;
  localparam logic [2:0] SEL_FUNCTION = 3'h3;
  localparam logic [2:0] SEL_TIMER = 3'h4;
  localparam logic [2:0] SEL_POWERDOWN = 3'h5;
  localparam logic [2:0] SEL_MUX = 3'h6;
  localparam logic [2:0] SEL_TEST = 3'h7;
  // channel word fields
  localparam int INT_LSB = 15;
  localparam int FRACTION_NUMERATOR_LSB = 3;
  // reference and modulus fields
  localparam int BOOST_BIT = 23;
  localparam int HALVER_BIT = 22;
  localparam int PRESCALER_BIT = 20;
  localparam int DOUBLER_BIT = 19;
  localparam int RDIV_LSB = 15;
  localparam int MOD_LSB = 3;
  // phase seed field
  localparam int PHASE_LSB = 3;
  // function register fields and reserved pattern
  localparam int GROUND_BIT = 5;
  localparam int POLARITY_BIT = 3;
  localparam logic [23:0] FUNC_FIXED = 24'h000050;
  // timer register fields and reserved pattern
  localparam int TSEL_LSB = 3;
  localparam int TCNT_LSB = 5;
  localparam logic [23:0] TIMER_FIXED = 24'h004000;
  // limits the host checks against; a word past them still goes out, only flagged
  localparam logic [7:0] INT_MIN = 8'h1A;
  localparam logic [3:0] RDIV_MIN = 4'h1;
  localparam logic [11:0] MOD_MIN = 12'h00D;
  // host command register map (port offsets)
  localparam logic [3:0] ADDR_CHANNEL = 4'h0;
  localparam logic [3:0] ADDR_REFMOD = 4'h1;
  localparam logic [3:0] ADDR_PHASE = 4'h2;
  localparam logic [3:0] ADDR_FUNCTION = 4'h3;
  localparam logic [3:0] ADDR_TIMER = 4'h4;
  localparam logic [3:0] ADDR_POWERDOWN = 4'h5;
  localparam logic [3:0] ADDR_MUX = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_SHADOW = 4'h9;
  // link timing: half serial bit time in system clocks
  localparam int LINK_HALF = 4;
  typedef enum logic [1:0] {SCRB_IDLE, SCRB_LOW, SCRB_HIGH, SCRB_LATCH}
    scrb_state_t;
endpackage

//--- core/scrb_copy_mem.sv
`timescale 1ns/1ns
`default_nettype none
// host copy of every word written, since the device cannot be read back
module scrb_copy_mem
  import scrb_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr,
  input wire logic [AW-1:0] waddr,
  input wire logic [WORD_W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WORD_W-1:0] rdata
);
  logic [WORD_W-1:0] mem [DEPTH];

  // storage; no reset so it maps onto plain ram
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

//--- core/scrb_shifter.sv
`timescale 1ns/1ns
`default_nettype none
// serialises one word msb first, then pulses the load strobe
module scrb_shifter
  import scrb_pkg::*;
#(
  parameter int HALF = LINK_HALF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [WORD_W-1:0] word,
  output logic busy,
  output logic done,
  output logic serial_clock,
  output logic serial_data,
  output logic load_strobe
);
  scrb_state_t state;
  logic [WORD_W-1:0] shreg;
  logic [CNT_W-1:0] bits;
  logic [7:0] tick;
  logic tick_end;

  assign tick_end = (tick == 8'(HALF - 1));
  assign busy = (state != SCRB_IDLE);

  // half bit timer, free while busy
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick <= 8'h00;
    end else if (state == SCRB_IDLE || tick_end) begin
      tick <= 8'h00;
    end else begin
      tick <= tick + 8'h01;
    end
  end

  // link sequencer: data set while clock low, device samples on rise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= SCRB_IDLE;
      shreg <= '0;
      bits <= '0;
      serial_clock <= 1'b0;
      serial_data <= 1'b0;
      load_strobe <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        SCRB_IDLE: begin
          if (start) begin
            serial_data <= word[WORD_W-1];
            shreg <= {word[WORD_W-2:0], 1'b0};
            bits <= CNT_W'(WORD_W - 1);
            state <= SCRB_LOW;
          end
        end
        SCRB_LOW: begin
          if (tick_end) begin
            serial_clock <= 1'b1;
            state <= SCRB_HIGH;
          end
        end
        SCRB_HIGH: begin
          if (tick_end) begin
            serial_clock <= 1'b0;
            if (bits == '0) begin
              load_strobe <= 1'b1;
              state <= SCRB_LATCH;
            end else begin
              serial_data <= shreg[WORD_W-1];
              shreg <= {shreg[WORD_W-2:0], 1'b0};
              bits <= bits - CNT_W'(1);
              state <= SCRB_LOW;
            end
          end
        end
        SCRB_LATCH: begin
          if (tick_end) begin
            load_strobe <= 1'b0;
            serial_data <= 1'b0;
            done <= 1'b1;
            state <= SCRB_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- core/scrb_host.sv
`timescale 1ns/1ns
`default_nettype none
module scrb_host
  import scrb_pkg::*;
#(
  parameter int HALF = LINK_HALF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic sync_go,
  output logic serial_clock,
  output logic serial_data,
  output logic load_strobe
);
  // one flag per select code, and the three fast lock timeout counters
  localparam int N_SEL = 2 ** SEL_W;
  localparam int N_TIMERS = 3;
  logic cmd_valid;
  logic [WORD_W-1:0] cmd_word;
  logic [WORD_W-1:0] pend_word;
  logic pend;
  logic hold_channel;
  logic busy;
  logic done;
  logic start;
  logic refused;
  logic range_err;
  logic [11:0] mod_copy;
  logic [7:0] int_v;
  logic [11:0] fraction_numerator_v;
  logic [3:0] rdiv_v;
  logic [11:0] mod_v;
  logic [11:0] phase_v;
  logic [1:0] tsel_v;
  logic bad;
  logic [WORD_W-1:0] copy_rdata;
  logic [2:0] copy_raddr;
  logic rd_q;
  logic [3:0] rd_addr_q;
  logic channel_sent;
  logic [15:0] words_sent;
  logic sync_q1;
  logic sync_q2;
  logic [WORD_W-1:0] fly_word;
  logic [N_SEL-1:0] seen_mask;
  logic [N_TIMERS-1:0] tsel_seen;
  logic init_done;
  logic chan_wait;
  logic [31:0] status_word;

  assign int_v = wdata[INT_LSB +: 8];
  assign fraction_numerator_v = wdata[FRACTION_NUMERATOR_LSB +: 12];
  assign rdiv_v = wdata[RDIV_LSB +: 4];
  assign mod_v = wdata[MOD_LSB +: 12];
  assign phase_v = wdata[PHASE_LSB +: 12];
  assign tsel_v = wdata[TSEL_LSB +: 2];

  // build the 24-bit word: select code in the low bits, reserved forced
  always_comb begin
    cmd_valid = wr;
    cmd_word = '0;
    unique case (addr)
      // integer and fraction; the top bit is reserved and sent low
      ADDR_CHANNEL: begin
        cmd_word = {1'b0, int_v, fraction_numerator_v, SEL_CHANNEL};
      end
      // boost, halver, doubler, divider, modulus go to the shadow
      ADDR_REFMOD: begin
        cmd_word = {wdata[BOOST_BIT], wdata[HALVER_BIT], 1'b0,
          wdata[PRESCALER_BIT], wdata[DOUBLER_BIT], rdiv_v, mod_v,
          SEL_REFMOD};
      end
      // the seed waits in the device until the next channel word
      ADDR_PHASE: begin
        cmd_word = {8'h00, 1'b0, phase_v, SEL_PHASE};
      end
      // reserved pattern is forced, so software cannot upset it
      ADDR_FUNCTION: begin
        cmd_word = FUNC_FIXED | {18'h0, wdata[GROUND_BIT], 1'b0,
          wdata[POLARITY_BIT],
          SEL_FUNCTION};
      end
      // nine-bit count and two-bit select over the fixed pattern
      ADDR_TIMER: begin
        cmd_word = TIMER_FIXED | {10'h0, wdata[TCNT_LSB +: 9], tsel_v,
          SEL_TIMER};
      end
      // power-down fields pass straight through
      ADDR_POWERDOWN: begin
        cmd_word = {16'h0, wdata[7:3], SEL_POWERDOWN};
      end
      // mode nibble and output select; the gap between is sent low
      ADDR_MUX: begin
        cmd_word = {8'h00, wdata[15:12], 5'h00, wdata[6:3], SEL_MUX};
      end
      // status, hold control and unmapped offsets build no word
      default: begin
        cmd_valid = 1'b0;
      end
    endcase
  end

  // range checks; an offending word still goes out, only the flag is set,
  // so software can probe the device with values it knows are odd
  always_comb begin
    bad = 1'b0;
    unique case (addr)
      // divide value floor, and fraction below the modulus last sent
      ADDR_CHANNEL: begin
        bad = (int_v < INT_MIN) || (fraction_numerator_v >= mod_copy);
      end
      // divider and modulus floors; the ceilings are the field widths
      ADDR_REFMOD: begin
        bad = (rdiv_v < RDIV_MIN) || (mod_v < MOD_MIN);
      end
      // the seed may reach the modulus itself
      ADDR_PHASE: begin
        bad = (phase_v > mod_copy);
      end
      // only three timeout counters exist; select 11 loads none
      ADDR_TIMER: begin
        bad = (&tsel_v);
      end
      default: begin
        bad = 1'b0;
      end
    endcase
  end

  // one pending word; a write while one waits is refused
  assign refused = cmd_valid && pend;
  // a channel word under hold waits for the synced go level, so two
  // hosts can release their channel words in the same cycle
  assign chan_wait = hold_channel && !sync_q2 &&
    (pend_word[SEL_W-1:0] == SEL_CHANNEL);
  // never start in the done cycle: the shifter is only just idle again
  assign start = pend && !busy && !done && !chan_wait;

  // pending slot and range flag (flag set wins over read clear)
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend <= 1'b0;
      pend_word <= '0;
      range_err <= 1'b0;
    end else begin
      if (cmd_valid && !pend) begin
        pend <= 1'b1;
        pend_word <= cmd_word;
      end else if (start) begin
        pend <= 1'b0;
      end
      if (cmd_valid && (bad || refused)) begin
        range_err <= 1'b1;
      // cleared after the read slot, so the read itself still shows it
      end else if (rd_q && rd_addr_q == ADDR_STATUS) begin
        range_err <= 1'b0;
      end
    end
  end

  // channel writes may wait for an external sync for coherent pairs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_channel <= 1'b0;
      sync_q1 <= 1'b0;
      sync_q2 <= 1'b0;
    end else begin
      sync_q1 <= sync_go;
      sync_q2 <= sync_q1;
      if (wr && addr == ADDR_SHADOW) begin
        hold_channel <= wdata[0];
      end
    end
  end

  // modulus copy for range checks; taken as soon as a refmod word has gone out, not after a channel write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mod_copy <= 12'hFFF;
      channel_sent <= 1'b0;
      words_sent <= 16'h0000;
    end else begin
      if (done) begin
        words_sent <= words_sent + 16'h0001;
        if (fly_word[SEL_W-1:0] == SEL_REFMOD) begin
          mod_copy <= fly_word[MOD_LSB +: 12];
        end
      end
      if (start) begin
        channel_sent <= (pend_word[SEL_W-1:0] == SEL_CHANNEL);
      end
    end
  end

  // word now on the link; pend_word may already hold the next one, so
  // anything acted on at done must come from this copy
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fly_word <= '0;
    end else if (start) begin
      fly_word <= pend_word;
    end
  end

  // one flag per register: set once a word with that select has started on the link
  for (genvar i = 0; i < N_SEL; i++) begin : g_seen
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        seen_mask[i] <= 1'b0;
      end else if (start && pend_word[SEL_W-1:0] == SEL_W'(i)) begin
        seen_mask[i] <= 1'b1;
      end
    end
  end

  // each timeout counter is loaded by its own timer write
  for (genvar t = 0; t < N_TIMERS; t++) begin : g_tsel
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        tsel_seen[t] <= 1'b0;
      end else if (start && pend_word[SEL_W-1:0] == SEL_TIMER &&
          pend_word[TSEL_LSB +: 2] == 2'(t)) begin
        tsel_seen[t] <= 1'b1;
      end
    end
  end

  // setup is complete once the function word and all timers have started on the link
  assign init_done = seen_mask[SEL_FUNCTION] && (&tsel_seen);

  // status word, low to high: busy, pending, error, last start was a
  // channel word, words sent, one flag per register sent, setup done
  assign status_word = {3'h0, init_done, seen_mask, words_sent,
    channel_sent, range_err, pend, busy};

  scrb_shifter #(.HALF(HALF)) u_shift (
    .clk(clk),
    .nrst(nrst),
    .start(start),
    .word(pend_word),
    .busy(busy),
    .done(done),
    .serial_clock(serial_clock),
    .serial_data(serial_data),
    .load_strobe(load_strobe)
  );

  // host keeps what it sent, since nothing comes back
  scrb_copy_mem #(.DEPTH(8), .AW(3)) u_copy (
    .clk(clk),
    .nrst(nrst),
    .wr(start),
    .waddr(pend_word[SEL_W-1:0]),
    .wdata(pend_word),
    .raddr(copy_raddr),
    .rdata(copy_rdata)
  );

  assign copy_raddr = addr[SEL_W-1:0];

  // read timing: memory returns in the following cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= 1'b0;
      rd_addr_q <= 4'h0;
    end else begin
      rd_q <= rd;
      rd_addr_q <= addr;
    end
  end

  // read data stand in the cycle after the strobe only
  always_comb begin
    rdata = 32'h0000_0000;
    if (rd_q) begin
      if (rd_addr_q == ADDR_STATUS) begin
        rdata = status_word;
      end else if (rd_addr_q == ADDR_SHADOW) begin
        rdata = {31'h0, hold_channel};
      end else if (rd_addr_q <= ADDR_MUX) begin
        // the test register is never sent, so it reads as unmapped
        rdata = {8'h00, copy_rdata};
      end
    end
  end
endmodule
`default_nettype wire

//--- test/scrb_host_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module scrb_host_monitor
  import scrb_pkg::*;
#(
  parameter int HALF = LINK_HALF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic sync_go,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic load_strobe
);
  logic [4:0] nbits;
  logic [7:0] hcnt;
  // link bits since the last strobe, so a short or long word shows up
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) nbits <= 5'h0;
    else if (load_strobe) nbits <= 5'h0;
    else if ($rose(serial_clock)) nbits <= nbits + 5'h1;
  end
  // length of the current high phase of the link clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) hcnt <= 8'h0;
    else if (serial_clock) hcnt <= hcnt + 8'h1;
    else hcnt <= 8'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  strobe_len_a: assert property (
    $rose(load_strobe) |-> load_strobe [*4] ##1 !load_strobe)
    else $error("load strobe length wrong");
  bit_count_a: assert property (
    $rose(load_strobe) |-> nbits == 5'h18)
    else $error("word not 24 bits");
  clk_high_a: assert property (
    $fell(serial_clock) |-> hcnt == HALF)
    else $error("link clock high phase wrong");
  clk_low_a: assert property (
    $fell(serial_clock) |-> !serial_clock [*4])
    else $error("link clock low phase short");
  data_hold_a: assert property (
    serial_clock && $past(serial_clock) |-> $stable(serial_data))
    else $error("data moved while clock high");
  strobe_clk_a: assert property (
    load_strobe |-> !serial_clock)
    else $error("clock high during strobe");
  read_idle_a: assert property (
    !$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read slot");
  unmapped_read_a: assert property (
    rd && (addr == 4'h7 || addr > 4'h9) |=> rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind scrb_host scrb_host_monitor #(.HALF(HALF)) scrb_host_monitor_inst (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .sync_go(sync_go), .serial_clock(serial_clock),
  .serial_data(serial_data), .load_strobe(load_strobe));
`default_nettype wire

//--- test/scrb_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module scrb_dev_model
  import scrb_pkg::*;
(
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic load_strobe,
  output logic [23:0] last_word,
  output logic [15:0] n_latched,
  output logic [23:0] live_ref,
  output logic [23:0] live_phase
);
  logic [23:0] shift = 24'h0;
  logic [23:0] regs [8];
  logic fast_lock = 1'b0;
  initial begin
    last_word = 24'h0;
    n_latched = 16'h0;
    live_ref = 24'h0;
    live_phase = 24'h0;
  end
  // msb enters first, so it sits on top after 24 edges
  always @(posedge serial_clock) shift <= {shift[22:0], serial_data};
  // write-only store; shadow fields go live only on a channel word
  always @(posedge load_strobe) begin
    regs[shift[2:0]] = shift;
    last_word = shift;
    if (shift[2:0] == SEL_CHANNEL) begin
      live_ref = regs[SEL_REFMOD];
      live_phase = regs[SEL_PHASE];
      fast_lock = 1'b1;
    end
    n_latched = n_latched + 16'h1;
  end
endmodule
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import scrb_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sync_go = 1'b0;
  logic [31:0] rdata;
  logic serial_clock, serial_data, load_strobe;
  logic [23:0] m_word, live_ref, live_phase, w, held;
  logic [15:0] m_count;
  logic [23:0] exp_q [$];
  logic [23:0] sent [8] = '{default: 24'h0};
  logic [15:0] rnd = 16'h29D9;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int n_words = 0;
  always #25 clk = ~clk;
  scrb_host scrb_host_inst (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sync_go(sync_go),
    .serial_clock(serial_clock), .serial_data(serial_data),
    .load_strobe(load_strobe));
  scrb_dev_model scrb_dev_model_inst (.serial_clock(serial_clock),
    .serial_data(serial_data), .load_strobe(load_strobe),
    .last_word(m_word), .n_latched(m_count), .live_ref(live_ref),
    .live_phase(live_phase));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // legal word for each register; fixed patterns come from the package
  function automatic logic [23:0] legal(input int a, input logic [15:0] r,
                                        input int p);
    case (a)
      0: return {1'b0, 8'(26 + r % 230),
                 12'(r % 13), 3'h0};
      1: return {r[0], r[1], 1'b0, r[2], r[3], 4'(1 + r % 15),
                 12'(13 + r % 4083), 3'h1};
      2: return {9'h0, 12'(r % 13), 3'h2};
      3: return FUNC_FIXED | {18'h0, r[1], 1'b0, r[0], 3'h3};
      4: return TIMER_FIXED | {10'h0, r[8:0], 2'(p), 3'h4};
      5: return {16'h0, r[4:0], 3'h5};
      default: return {8'h0, r[3:0], 5'h0, r[7:4], 3'h6};
    endcase
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  // polls status until idle; the error bit clears on read, so gather it
  task wait_idle(output logic err);
    logic [31:0] s;
    err = 1'b0;
    for (int i = 0; i < 400; i++) begin
      rd_reg(ADDR_STATUS, s);
      err = err | s[2];
      if (s[1:0] === 2'b00) break;
    end
  endtask
  task note(input logic [3:0] a, input logic [23:0] x);
    exp_q.push_back(x);
    sent[a[2:0]] = x;
    n_words++;
  endtask
  task send(input logic [3:0] a, input logic [23:0] x, input logic e);
    logic err;
    logic [31:0] v;
    note(a, x);
    wr_reg(a, {8'h0, x});
    wait_idle(err);
    check({31'h0, err}, {31'h0, e});
    rd_reg(a, v);
    check(v, {8'h0, x});
  endtask
  // each word seen by the far side is matched to the oldest note
  always @(m_count) if (m_count !== 16'h0)
    check({8'h0, m_word}, exp_q.size() > 0 ?
          {8'h0, exp_q.pop_front()} : 32'hFFFFFFFF);
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      complete_run;
    end
  end
  initial begin
    logic [31:0] v;
    logic e;
    logic [15:0] c;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      held = sent[1];
      for (int a = 1; a < 8; a++) begin
        rnd = lfsr(rnd);
        send(4'(a % 7), legal(a % 7, rnd, p), 1'b0);
        if (a == 6) check({8'h0, live_ref}, {8'h0, held});
      end
      check({8'h0, live_ref}, {8'h0, sent[1]});
      check({8'h0, live_phase}, {8'h0, sent[2]});
    end
    rd_reg(ADDR_STATUS, v);
    check({12'h0, v[19:3], 3'h0}, {12'h0, 16'(n_words), 4'h8});
    check({20'h0, v[31:20]}, 32'h0000017F);
    // one word shifting, one pending: a third write is dropped, flagged
    w = legal(5, lfsr(rnd), 0);
    note(4'h5, w);
    wr_reg(4'h5, {8'h0, w});
    note(4'h5, w);
    wr_reg(4'h5, {8'h0, w});
    wr_reg(4'h5, 32'h000000ED);
    wait_idle(e);
    check({31'h0, e}, 32'h1);
    send(ADDR_CHANNEL, {1'b0, 8'h19, 12'h0, 3'h0}, 1'b1);
    send(ADDR_REFMOD, {9'h000, 12'h0FF, 3'h1}, 1'b1);
    send(ADDR_REFMOD, {9'h001, 12'h00C, 3'h1}, 1'b1);
    send(ADDR_PHASE, {9'h0, 12'hFFF, 3'h2}, 1'b1);
    w = TIMER_FIXED | {10'h0, 9'h01C, 2'h3, 3'h4};
    send(ADDR_TIMER, w, 1'b1);
    wr_reg(4'h7, 32'h000000FF);
    rd_reg(4'h7, v);
    check(v, 32'h0);
    rd_reg(4'hC, v);
    check(v, 32'h0);
    // held channel word waits for the sync input
    wr_reg(ADDR_SHADOW, 32'h1);
    c = m_count;
    w = legal(0, lfsr(rnd), 0);
    note(ADDR_CHANNEL, w);
    wr_reg(ADDR_CHANNEL, {8'h0, w});
    repeat (40) @(posedge clk);
    check({16'h0, m_count}, {16'h0, c});
    sync_go <= 1'b1;
    wait_idle(e);
    check({16'h0, m_count}, {16'h0, c + 16'h1});
    wr_reg(ADDR_SHADOW, 32'h0);
    repeat (20) @(posedge clk);
    check(exp_q.size(), 32'h0);
    complete_run;
  end
endmodule
`default_nettype wire
